// file: design/test_mux_settle_pkg.sv
// Package for the test multiplexer and PLL settling configuration block.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
package test_mux_settle_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_TEST_BUS_SEL = 8'h51;
	localparam logic [7:0] IDX_PLL_SETTLE_TIME_CFG = 8'h53;
	localparam logic [7:0] IDX_POWER_BOOST_PREAMBLE_CFG = 8'h54;
	localparam logic [7:0] IDX_PIN_FUNCTION = 8'h60;
	localparam logic [7:0] IDX_BLOCK_STATUS = 8'h61;
	localparam int ADDR_W = 10;
	localparam logic [ADDR_W-1:0] ADDR_TEST_BUS_SEL = {IDX_TEST_BUS_SEL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PLL_SETTLE_TIME_CFG = {IDX_PLL_SETTLE_TIME_CFG, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_POWER_BOOST_PREAMBLE_CFG =
		{IDX_POWER_BOOST_PREAMBLE_CFG, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PIN_FUNCTION = {IDX_PIN_FUNCTION, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_BLOCK_STATUS = {IDX_BLOCK_STATUS, 2'b00};

	// Reset values
	localparam logic [7:0] RST_TEST_BUS_SEL = 8'h00;
	localparam logic [7:0] RST_PLL_SETTLE_TIME_CFG = 8'h52;
	localparam logic [7:0] RST_POWER_BOOST_PREAMBLE_CFG = 8'h54;
	localparam logic [2:0] RST_PIN_FUNCTION = 3'h0;

	// Field positions
	localparam int TEST_SEL_LSB = 0;
	localparam int TEST_SEL_MSB = 5;
	localparam int SOFT_SETTLE_LSB = 3;
	localparam int SOFT_SETTLE_MSB = 7;
	localparam int INIT_SETTLE_LSB = 0;
	localparam int INIT_SETTLE_MSB = 2;
	localparam int BAD_PRE_TH_LSB = 2;
	localparam int BAD_PRE_TH_MSB = 5;
	localparam int AMP_REG_BOOST_BIT = 1;
	localparam int AMP_BIAS_BOOST_BIT = 0;

	// Test bus codes handled here
	localparam logic [5:0] TEST_SEL_PACKET_RX = 6'h32;
	localparam logic [5:0] TEST_SEL_CONVERTER = 6'h3f;

	// Settling step timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETTLE_STEP_US = 10;
	localparam int SETTLE_STEP_CYCLES = (SETTLE_STEP_US * 1000) / CLK_PERIOD_NS;
	localparam int SUBCOUNT_W = 16;
	localparam int PREAMBLE_WINDOW_MULT = 4;

	typedef enum logic [1:0] {
		SETTLE_IDLE = 2'b01,
		SETTLE_RUN = 2'b10
	} settle_e;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} avmm_req_s;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} avmm_rsp_s;

	typedef struct packed {
		logic [2:0] out;
		logic [2:0] oe;
	} gpio_pins_s;

	typedef struct packed {
		avmm_rsp_s rsp;
		logic [7:0] testBusReg;
		logic [7:0] settleReg;
		logic [7:0] boostReg;
		logic [2:0] pinMuxEn;
		gpio_pins_s pins;
		settle_e settleState;
		logic [5:0] stepsLeft;
		logic [SUBCOUNT_W-1:0] subCount;
		logic settleDone;
		logic windowOpen;
		logic [5:0] ticksLeft;
		logic windowEnd;
	} state_s;

endpackage

// file: design/test_mux_settle_cfg.sv
// Register bank with digital test multiplexer, PLL settling timer and
// invalid-preamble evaluation window. Internal signals come from logic on
// clk_sys; registers are reached over Avalon-MM with waitrequest.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// [R1] Six-bit test code; pins show it when enabled
// [R2] Code 50: search, sync found, receive data
// [R3] Code 63: converter enable, refdac enable, reset
// [R4] Cold start settle equals soft plus initial
// [R5] Soft field 7:3, 10 us steps, 100 us
// [R6] Initial field 2:0, 10 us steps, 20 us
// [R7] Preamble window is four times threshold bits
// [R8] Code n gives n times 10 us cycles
module test_mux_settle_cfg
	import test_mux_settle_pkg::*;
#(
	parameter int STEP_CYCLES = SETTLE_STEP_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register bus
	input wire avmm_req_s bus,
	output var avmm_rsp_s busRsp,
	// Test multiplexer sources
	input wire logic packetSearchActive,
	input wire logic syncWordDetected,
	input wire logic rxDataIn,
	input wire logic convEnable,
	input wire logic convRefDacEnable,
	input wire logic convReset_n,
	// General-purpose pins
	output var gpio_pins_s gpio,
	// PLL settling
	input wire logic tuneStart,
	input wire logic calDone,
	output logic settleBusy,
	output logic settleDone,
	// Preamble evaluation
	input wire logic bitTick,
	input wire logic preambleStart,
	output logic preambleWindowOpen,
	output logic preambleWindowEnd,
	// Amplifier boost controls
	output logic ampRegulatorBoost,
	output logic ampBiasBoost
);

	state_s st;
	state_s next_st;

	always_comb begin
		logic [31:0] readValue;
		logic [2:0] muxVal;
		logic [4:0] softField;
		logic [2:0] initField;
		logic [3:0] thField;
		readValue = 32'h0;
		muxVal = 3'h0;
		softField = st.settleReg[SOFT_SETTLE_MSB:SOFT_SETTLE_LSB];
		initField = st.settleReg[INIT_SETTLE_MSB:INIT_SETTLE_LSB];
		thField = st.boostReg[BAD_PRE_TH_MSB:BAD_PRE_TH_LSB];
		next_st = st;
		next_st.settleDone = 1'b0;
		next_st.windowEnd = 1'b0;

		// Read mux; unmapped addresses read zero
		unique case (bus.address)
			ADDR_TEST_BUS_SEL: readValue = {24'h0, st.testBusReg};
			ADDR_PLL_SETTLE_TIME_CFG: readValue = {24'h0, st.settleReg};
			ADDR_POWER_BOOST_PREAMBLE_CFG: readValue = {24'h0, st.boostReg};
			ADDR_PIN_FUNCTION: readValue = {29'h0, st.pinMuxEn};
			ADDR_BLOCK_STATUS: readValue = {30'h0, st.windowOpen, st.settleState[1]};
			default: readValue = 32'h0;
		endcase

		// One wait cycle per access, then the answer edge
		if ((bus.read || bus.write) && st.rsp.waitrequest) begin
			next_st.rsp.waitrequest = 1'b0;
			if (bus.read) begin
				next_st.rsp.readdata = readValue;
			end
		end else begin
			next_st.rsp.waitrequest = 1'b1;
		end

		// Writes take effect at the edge where waitrequest is seen low
		if (bus.write && !st.rsp.waitrequest && bus.byteenable[0]) begin
			unique case (bus.address)
				ADDR_TEST_BUS_SEL: next_st.testBusReg = bus.writedata[7:0];
				ADDR_PLL_SETTLE_TIME_CFG: next_st.settleReg = bus.writedata[7:0];
				ADDR_POWER_BOOST_PREAMBLE_CFG: next_st.boostReg = bus.writedata[7:0];
				ADDR_PIN_FUNCTION: next_st.pinMuxEn = bus.writedata[2:0];
				default: next_st.pinMuxEn = st.pinMuxEn;
			endcase
		end

		// Test multiplexer; codes not handled here give low
		unique case (st.testBusReg[TEST_SEL_MSB:TEST_SEL_LSB])
			TEST_SEL_PACKET_RX: muxVal = {rxDataIn, syncWordDetected, packetSearchActive}; // R2
			TEST_SEL_CONVERTER: muxVal = {convReset_n, convRefDacEnable, convEnable}; // R3
			default: muxVal = 3'h0;
		endcase
		next_st.pins.out = muxVal & st.pinMuxEn; // R1
		next_st.pins.oe = st.pinMuxEn; // R1

		// Settling timer counts whole 10 us steps
		unique case (st.settleState)
			SETTLE_IDLE: begin
				next_st.subCount = '0;
			end
			SETTLE_RUN: begin
				if (st.stepsLeft == 6'h0) begin
					next_st.settleState = SETTLE_IDLE;
					next_st.settleDone = 1'b1;
				end else if (st.subCount == SUBCOUNT_W'(STEP_CYCLES - 1)) begin
					next_st.subCount = '0; // R8
					next_st.stepsLeft = st.stepsLeft - 6'h1; // R8
				end else begin
					next_st.subCount = st.subCount + 1'b1;
				end
			end
		endcase
		// A new start restarts a running interval; cold start wins
		if (calDone) begin
			next_st.settleState = SETTLE_RUN;
			next_st.subCount = '0;
			next_st.stepsLeft = {1'b0, softField} + {3'h0, initField}; // R4 R6
		end else if (tuneStart) begin
			next_st.settleState = SETTLE_RUN;
			next_st.subCount = '0;
			next_st.stepsLeft = {1'b0, softField}; // R5
		end

		// Invalid-preamble window in bit periods
		if (st.windowOpen) begin
			if (st.ticksLeft == 6'h0) begin
				next_st.windowOpen = 1'b0;
				next_st.windowEnd = 1'b1;
			end else if (bitTick) begin
				next_st.ticksLeft = st.ticksLeft - 6'h1;
			end
		end
		if (preambleStart) begin
			next_st.windowOpen = 1'b1;
			next_st.ticksLeft = {thField, 2'b00}; // R7
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st.rsp.readdata <= 32'h0;
			st.rsp.waitrequest <= 1'b1;
			st.testBusReg <= RST_TEST_BUS_SEL;
			st.settleReg <= RST_PLL_SETTLE_TIME_CFG; // R5 R6
			st.boostReg <= RST_POWER_BOOST_PREAMBLE_CFG;
			st.pinMuxEn <= RST_PIN_FUNCTION;
			st.pins.out <= 3'h0;
			st.pins.oe <= 3'h0;
			st.settleState <= SETTLE_IDLE;
			st.stepsLeft <= 6'h0;
			st.subCount <= '0;
			st.settleDone <= 1'b0;
			st.windowOpen <= 1'b0;
			st.ticksLeft <= 6'h0;
			st.windowEnd <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign busRsp = st.rsp;
	assign gpio = st.pins;
	assign settleBusy = st.settleState[1];
	assign settleDone = st.settleDone;
	assign preambleWindowOpen = st.windowOpen;
	assign preambleWindowEnd = st.windowEnd;
	// Boost bits only drive analog controls; no digital behaviour here
	assign ampRegulatorBoost = st.boostReg[AMP_REG_BOOST_BIT];
	assign ampBiasBoost = st.boostReg[AMP_BIAS_BOOST_BIT];

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence s_bus_request;
		(bus.read || bus.write) && busRsp.waitrequest;
	endsequence

	sequence s_bus_answer;
		!busRsp.waitrequest ##1 busRsp.waitrequest;
	endsequence

	property p_bus_answer;
		s_bus_request |=> s_bus_answer;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("Bus access not answered after one wait cycle");

	property p_pin_disabled;
		!st.pinMuxEn[0] |=> !gpio.oe[0] && !gpio.out[0];
	endproperty
	a_pin_disabled: assert property (p_pin_disabled) // R1
		else $error("Pin driven without test mux function");

	property p_code_packet;
		(st.pinMuxEn == 3'h7 && st.testBusReg[5:0] == TEST_SEL_PACKET_RX) |=>
			gpio.out == {$past(rxDataIn), $past(syncWordDetected), $past(packetSearchActive)};
	endproperty
	a_code_packet: assert property (p_code_packet) // R2
		else $error("Packet signals not on test pins");

	property p_code_converter;
		(st.pinMuxEn == 3'h7 && st.testBusReg[5:0] == TEST_SEL_CONVERTER) |=>
			gpio.out == {$past(convReset_n), $past(convRefDacEnable), $past(convEnable)};
	endproperty
	a_code_converter: assert property (p_code_converter) // R3
		else $error("Converter signals not on test pins");

	property p_cold_start;
		calDone |=> settleBusy && st.stepsLeft ==
			6'({1'b0, $past(st.settleReg[7:3])} + {3'h0, $past(st.settleReg[2:0])});
	endproperty
	a_cold_start: assert property (p_cold_start) // R4
		else $error("Cold start interval is not soft plus initial");

	property p_soft_start;
		(tuneStart && !calDone) |=> settleBusy && st.stepsLeft == {1'b0, $past(st.settleReg[7:3])};
	endproperty
	a_soft_start: assert property (p_soft_start) // R5
		else $error("Soft settling interval loaded wrong");

	property p_zero_interval;
		(calDone && st.settleReg[7:3] == 5'h0 && st.settleReg[2:0] == 3'h0) ##1
			(!calDone && !tuneStart) |=> settleDone && !settleBusy;
	endproperty
	a_zero_interval: assert property (p_zero_interval) // R6
		else $error("Zero interval did not finish at once");

	property p_step_length;
		(settleBusy && st.subCount == SUBCOUNT_W'(STEP_CYCLES - 1) && st.stepsLeft != 6'h0
			&& !calDone && !tuneStart) |=> st.subCount == '0 && st.stepsLeft == $past(st.stepsLeft) - 6'h1;
	endproperty
	a_step_length: assert property (p_step_length) // R8
		else $error("Settling step not counted in clock cycles");

	property p_done_cause;
		settleDone |-> $past(settleBusy) && $past(st.stepsLeft) == 6'h0;
	endproperty
	a_done_cause: assert property (p_done_cause) // R8
		else $error("Settling done without elapsed interval");

	property p_window_load;
		preambleStart |=> preambleWindowOpen && st.ticksLeft == 6'($past(st.boostReg[5:2]) * 4);
	endproperty
	a_window_load: assert property (p_window_load) // R7
		else $error("Preamble window length is not four times threshold");

	property p_window_end;
		preambleWindowEnd |-> $past(preambleWindowOpen) && $past(st.ticksLeft) == 6'h0;
	endproperty
	a_window_end: assert property (p_window_end) // R7
		else $error("Preamble window closed early");

	// Enables follow the pin function bits one cycle later
	property p_pin_enable;
		1'b1 |=> gpio.oe == $past(st.pinMuxEn);
	endproperty
	a_pin_enable: assert property (p_pin_enable) // R1
		else $error("Pin enables do not follow pin function");

	property p_pin_mask;
		(gpio.out & ~gpio.oe) == 3'h0;
	endproperty
	a_pin_mask: assert property (p_pin_mask) // R1
		else $error("Test value shown on a pin that is not enabled");

	// Only two codes are wired here; anything else must stay quiet
	property p_code_other;
		(st.testBusReg[5:0] != TEST_SEL_PACKET_RX && st.testBusReg[5:0] != TEST_SEL_CONVERTER)
			|=> gpio.out == 3'h0;
	endproperty
	a_code_other: assert property (p_code_other) // R1
		else $error("Unhandled test code drives the pins");

	property p_wait_idle;
		!(bus.read || bus.write) |=> busRsp.waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle)
		else $error("Bus answered without a request");

	property p_settle_write;
		(bus.write && !busRsp.waitrequest && bus.byteenable[0]
			&& bus.address == ADDR_PLL_SETTLE_TIME_CFG) |=> st.settleReg == $past(bus.writedata[7:0]);
	endproperty
	a_settle_write: assert property (p_settle_write) // R5
		else $error("Settling register write did not land");

	property p_busy_end;
		$fell(settleBusy) |-> settleDone;
	endproperty
	a_busy_end: assert property (p_busy_end) // R8
		else $error("Settling ended without done pulse");

endmodule

`default_nettype wire

// file: bench/test_mux_and_pll_settle_cfg_tb_top.sv
// Self-checking bench for the test mux and PLL settling register block.
// Assumes the package constants and a 100 MHz clk_sys; bus master follows waitrequest.
`timescale 1ns/1ns
`default_nettype none
module test_mux_and_pll_settle_cfg_tb_top;
	import test_mux_settle_pkg::*;
	localparam int STEP = 4;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	avmm_req_s bus = '0;
	avmm_rsp_s busRsp;
	gpio_pins_s gpio;
	logic [5:0] src = '0;
	logic tuneStart = 1'b0, calDone = 1'b0, bitTick = 1'b0, preambleStart = 1'b0;
	logic settleBusy, settleDone, preambleWindowOpen, preambleWindowEnd;
	logic ampRegulatorBoost, ampBiasBoost;
	logic [31:0] rd;
	int n_mismatch = 0;
	int checks_done = 0;
	always #5 clk_sys = ~clk_sys;
	test_mux_settle_cfg #(.STEP_CYCLES(STEP)) uut (.clk_sys(clk_sys), .reset(reset),
		.bus(bus), .busRsp(busRsp), .packetSearchActive(src[0]), .syncWordDetected(src[1]),
		.rxDataIn(src[2]), .convEnable(src[3]), .convRefDacEnable(src[4]),
		.convReset_n(src[5]), .gpio(gpio), .tuneStart(tuneStart), .calDone(calDone),
		.settleBusy(settleBusy), .settleDone(settleDone), .bitTick(bitTick),
		.preambleStart(preambleStart), .preambleWindowOpen(preambleWindowOpen),
		.preambleWindowEnd(preambleWindowEnd), .ampRegulatorBoost(ampRegulatorBoost),
		.ampBiasBoost(ampBiasBoost));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results;
		if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{address: a, read: !w, write: w, writedata: {24'h0, d}, byteenable: 4'hf};
		do @(posedge clk_sys); while (busRsp.waitrequest !== 1'b0);
		rd = busRsp.readdata;
		bus.read <= 1'b0;
		bus.write <= 1'b0;
	endtask
	task automatic reg_resets;
		acc(0, ADDR_TEST_BUS_SEL, 0); chk(rd, RST_TEST_BUS_SEL);
		acc(0, ADDR_PLL_SETTLE_TIME_CFG, 0); chk(rd, 8'h52);
		acc(0, ADDR_POWER_BOOST_PREAMBLE_CFG, 0); chk(rd, 8'h54);
		acc(0, ADDR_PIN_FUNCTION, 0); chk(rd, 8'h00);
		acc(0, 10'h3fc, 0); chk(rd, 8'h00);
		chk({ampRegulatorBoost, ampBiasBoost}, 2'b00);
	endtask
	// Drive every source pattern; one cycle later expect it on the pins when live, else zero
	task automatic mux_code(input logic [5:0] code, input int sh, input logic live);
		acc(1, ADDR_TEST_BUS_SEL, {2'b00, code});
		for (int p = 0; p < 8; p++) begin
			@(posedge clk_sys);
			src <= 6'(p << sh);
			@(posedge clk_sys);
			@(negedge clk_sys);
			chk(gpio.out, live ? p[2:0] : 3'h0);
			chk(gpio.oe, 3'h7);
		end
	endtask
	task automatic test_mux;
		acc(1, ADDR_PIN_FUNCTION, 8'h07);
		mux_code(TEST_SEL_PACKET_RX, 0, 1'b1);
		mux_code(TEST_SEL_CONVERTER, 3, 1'b1);
		mux_code(6'h31, 0, 1'b0);
		// Packet sources still all high; only enabled pins may show them
		acc(1, ADDR_PIN_FUNCTION, 8'h05);
		acc(1, ADDR_TEST_BUS_SEL, {2'b00, TEST_SEL_PACKET_RX});
		repeat (2) @(negedge clk_sys);
		chk(gpio.out, 3'h5);
		chk(gpio.oe, 3'h5);
		acc(1, ADDR_PIN_FUNCTION, 8'h00);
		repeat (2) @(negedge clk_sys);
		chk(gpio.oe, 3'h0);
		chk(gpio.out, 3'h0);
	endtask
	// Count from the start pulse until the done pulse is seen
	task automatic settle(input logic cold, input int steps);
		int cnt;
		@(posedge clk_sys);
		if (cold) calDone <= 1'b1;
		else tuneStart <= 1'b1;
		@(posedge clk_sys);
		calDone <= 1'b0;
		tuneStart <= 1'b0;
		cnt = 0;
		@(negedge clk_sys);
		chk(settleBusy, 1'b1);
		do begin
			cnt++;
			if (cnt > 1) @(negedge clk_sys);
		end while (settleDone !== 1'b1 && cnt < 500);
		chk(cnt, steps * STEP + 2);
		chk(settleBusy, 1'b0);
	endtask
	task automatic settling;
		acc(1, ADDR_PLL_SETTLE_TIME_CFG, {5'd2, 3'd1});
		acc(0, ADDR_PLL_SETTLE_TIME_CFG, 0); chk(rd, 8'h11);
		settle(1'b0, 2);
		settle(1'b1, 3);
		settle(1'b1, 3);
		acc(1, ADDR_PLL_SETTLE_TIME_CFG, 8'h00);
		settle(1'b1, 0);
		// Reset after the last run must bring the settling register back
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		acc(0, ADDR_PLL_SETTLE_TIME_CFG, 0); chk(rd, RST_PLL_SETTLE_TIME_CFG);
		chk(settleBusy, 1'b0);
	endtask
	task automatic preamble;
		acc(1, ADDR_POWER_BOOST_PREAMBLE_CFG, {2'b00, 4'd1, 2'b11});
		@(negedge clk_sys);
		chk({ampRegulatorBoost, ampBiasBoost}, 2'b11);
		@(posedge clk_sys);
		preambleStart <= 1'b1;
		@(posedge clk_sys);
		preambleStart <= 1'b0;
		acc(0, ADDR_BLOCK_STATUS, 0); chk(rd, 32'h2);
		// Window spans four bit periods for a threshold of one
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			bitTick <= 1'b1;
			@(posedge clk_sys);
			bitTick <= 1'b0;
			@(negedge clk_sys);
			chk({preambleWindowOpen, preambleWindowEnd}, 2'b10);
		end
		@(negedge clk_sys);
		chk({preambleWindowOpen, preambleWindowEnd}, 2'b01);
		acc(0, ADDR_BLOCK_STATUS, 0); chk(rd, 32'h0);
	endtask
	initial begin
		#200000;
		n_mismatch++;
		results;
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		reg_resets;
		test_mux;
		settling;
		preamble;
		results;
	end
endmodule
`default_nettype wire
